// [core_sfr_pkg.sv]
package core_sfr_pkg;

    // ****************************************************
    // Register addresses in special register space
    // ****************************************************
    localparam logic [7:0] STACK_TOP_ADDR = 8'h81;
    localparam logic [7:0] POINTER_LOW_ADDR = 8'h82;
    localparam logic [7:0] POINTER_HIGH_ADDR = 8'h83;
    localparam logic [7:0] STATUS_WORD_ADDR = 8'hd0;
    localparam logic [7:0] PRIMARY_ADDR = 8'he0;
    localparam logic [7:0] SECONDARY_ADDR = 8'hf0;

    // ****************************************************
    // Reset values
    // ****************************************************
    localparam logic [7:0] STACK_TOP_RESET = 8'h07;
    localparam logic [7:0] POINTER_LOW_RESET = 8'h00;
    localparam logic [7:0] POINTER_HIGH_RESET = 8'h00;
    localparam logic [7:0] STATUS_WORD_RESET = 8'h00;
    localparam logic [7:0] PRIMARY_RESET = 8'h00;
    localparam logic [7:0] SECONDARY_RESET = 8'h00;

    // ****************************************************
    // Status word field positions
    // ****************************************************
    localparam int CARRY_POS = 7;
    localparam int HALF_CARRY_POS = 6;
    localparam int USER_A_POS = 5;
    localparam int BANK_HI_POS = 4;
    localparam int BANK_LO_POS = 3;
    localparam int RANGE_POS = 2;
    localparam int USER_B_POS = 1;
    localparam int PARITY_POS = 0;

    // Bit addresses with this bit set fall in special register space
    localparam int BIT_SPACE_POS = 7;

    typedef enum logic [2:0] {
        ARITH_NONE,
        ARITH_ADD,
        ARITH_ADDC,
        ARITH_SUBB,
        ARITH_MUL,
        ARITH_DIV
    } arith_op_type;

endpackage

// [arith_flag_unit.sv]
`timescale 1ns/1ns
module arith_flag_unit (
    input wire core_sfr_pkg::arith_op_type op_in,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] b_in,
    input wire logic [7:0] operand_in,
    input wire logic carry_in,
    output logic [7:0] res_a_out,
    output logic [7:0] res_b_out,
    output logic b_write_out,
    output logic carry_out,
    output logic half_out,
    output logic range_out
);

    logic [8:0] full;
    logic [4:0] nib;
    logic [15:0] prod;
    logic cin;

    always_comb begin
        cin = (op_in == core_sfr_pkg::ARITH_ADDC || op_in == core_sfr_pkg::ARITH_SUBB) ? carry_in : 1'b0;
        full = 9'h000;
        nib = 5'h00;
        prod = acc_in * b_in;
        res_a_out = acc_in;
        res_b_out = b_in;
        b_write_out = 1'b0;
        carry_out = carry_in;
        half_out = 1'b0;
        range_out = 1'b0;
        unique case (op_in)
            core_sfr_pkg::ARITH_ADD, core_sfr_pkg::ARITH_ADDC: begin
                full = {1'b0, acc_in} + {1'b0, operand_in} + {8'h00, cin};
                nib = {1'b0, acc_in[3:0]} + {1'b0, operand_in[3:0]} + {4'h0, cin};
                res_a_out = full[7:0];
                carry_out = full[8];
                half_out = nib[4];
                range_out = (acc_in[7] == operand_in[7]) && (full[7] != acc_in[7]);
            end
            core_sfr_pkg::ARITH_SUBB: begin
                // Borrow appears as the ninth bit of the wrapped difference
                full = {1'b0, acc_in} - {1'b0, operand_in} - {8'h00, cin};
                nib = {1'b0, acc_in[3:0]} - {1'b0, operand_in[3:0]} - {4'h0, cin};
                res_a_out = full[7:0];
                carry_out = full[8];
                half_out = nib[4];
                range_out = (acc_in[7] != operand_in[7]) && (full[7] != acc_in[7]);
            end
            core_sfr_pkg::ARITH_MUL: begin
                res_a_out = prod[7:0];
                res_b_out = prod[15:8];
                b_write_out = 1'b1;
                carry_out = 1'b0;
                range_out = |prod[15:8];
            end
            core_sfr_pkg::ARITH_DIV: begin
                carry_out = 1'b0;
                // Zero divisor leaves both operands unchanged
                if (b_in == 8'h00) begin
                    range_out = 1'b1;
                end else begin
                    res_a_out = acc_in / b_in;
                    res_b_out = acc_in % b_in;
                    b_write_out = 1'b1;
                end
            end
            core_sfr_pkg::ARITH_NONE: begin
                carry_out = carry_in;
            end
        endcase
    end

endmodule

// [core_special_registers.sv]
`timescale 1ns/1ns
module core_special_registers (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_rd_in,
    output logic [7:0] sfr_rdata_out,
    output logic sfr_hit_out,
    input wire logic [7:0] bit_addr_in,
    input wire logic bit_wr_in,
    input wire logic bit_wdata_in,
    input wire logic bit_rd_in,
    output logic bit_rdata_out,
    input wire logic push_in,
    input wire logic pop_in,
    output logic [7:0] stack_top_out,
    input wire logic pointer_inc_in,
    output logic [15:0] indirect_pointer_out,
    input wire core_sfr_pkg::arith_op_type arith_op_in,
    input wire logic [7:0] arith_operand_in,
    output logic [7:0] primary_working_reg_out,
    output logic [7:0] secondary_working_reg_out,
    output logic [7:0] program_status_word_out,
    input wire logic [2:0] working_reg_sel_in,
    output logic [7:0] working_reg_addr_out
);

    // ****************************************************
    // Storage
    // ****************************************************
    logic [7:0] stack_top_pointer_r;
    logic [7:0] stack_top_pointer_nxt;
    logic [7:0] indirect_pointer_low_r;
    logic [7:0] indirect_pointer_low_nxt;
    logic [7:0] indirect_pointer_high_r;
    logic [7:0] indirect_pointer_high_nxt;
    logic [7:0] program_status_word_r;
    logic [7:0] program_status_word_nxt;
    logic [7:0] primary_working_reg_r;
    logic [7:0] primary_working_reg_nxt;
    logic [7:0] secondary_working_reg_r;
    logic [7:0] secondary_working_reg_nxt;
    logic [7:0] sfr_rdata_r;
    logic bit_rdata_r;

    // ****************************************************
    // Address decode
    // ****************************************************
    // Reads of unassigned addresses return zero and never disturb state
    function automatic logic [7:0] read_sfr(
        input logic [7:0] addr,
        input logic [7:0] sp,
        input logic [7:0] lo,
        input logic [7:0] hi,
        input logic [7:0] program_status_word,
        input logic [7:0] acc,
        input logic [7:0] b
    );
        logic [7:0] val;
        val = 8'h00;
        unique case (addr)
            core_sfr_pkg::STACK_TOP_ADDR: val = sp;
            core_sfr_pkg::POINTER_LOW_ADDR: val = lo;
            core_sfr_pkg::POINTER_HIGH_ADDR: val = hi;
            core_sfr_pkg::STATUS_WORD_ADDR: val = program_status_word;
            core_sfr_pkg::PRIMARY_ADDR: val = acc;
            core_sfr_pkg::SECONDARY_ADDR: val = b;
            default: val = 8'h00;
        endcase
        return val;
    endfunction

    wire logic [7:0] bit_byte_addr = {bit_addr_in[7:3], 3'b000};
    wire logic bit_in_sfr_space = bit_addr_in[core_sfr_pkg::BIT_SPACE_POS];
    // Only the status word and the two working registers take single-bit access
    wire logic bit_target_ok = bit_in_sfr_space &&
        (bit_byte_addr == core_sfr_pkg::STATUS_WORD_ADDR ||
         bit_byte_addr == core_sfr_pkg::PRIMARY_ADDR ||
         bit_byte_addr == core_sfr_pkg::SECONDARY_ADDR);
    wire logic [7:0] bit_mask = 8'h01 << bit_addr_in[2:0];
    wire logic [7:0] bit_byte_val = read_sfr(bit_byte_addr, stack_top_pointer_r, indirect_pointer_low_r,
        indirect_pointer_high_r, program_status_word_r, primary_working_reg_r, secondary_working_reg_r);
    wire logic [7:0] bit_merged = (bit_byte_val & ~bit_mask) | (bit_wdata_in ? bit_mask : 8'h00);

    // A byte write takes precedence over a bit write in the same cycle
    wire logic wr_en = sfr_wr_in | (bit_wr_in & bit_target_ok);
    wire logic [7:0] wr_addr = sfr_wr_in ? sfr_addr_in : bit_byte_addr;
    wire logic [7:0] wr_data = sfr_wr_in ? sfr_wdata_in : bit_merged;

    wire logic wr_stack = wr_en && wr_addr == core_sfr_pkg::STACK_TOP_ADDR;
    wire logic wr_low = wr_en && wr_addr == core_sfr_pkg::POINTER_LOW_ADDR;
    wire logic wr_high = wr_en && wr_addr == core_sfr_pkg::POINTER_HIGH_ADDR;
    wire logic wr_status = wr_en && wr_addr == core_sfr_pkg::STATUS_WORD_ADDR;
    wire logic wr_primary = wr_en && wr_addr == core_sfr_pkg::PRIMARY_ADDR;
    wire logic wr_secondary = wr_en && wr_addr == core_sfr_pkg::SECONDARY_ADDR;

    // No page input exists: every register answers on all pages
    assign sfr_hit_out = sfr_addr_in == core_sfr_pkg::STACK_TOP_ADDR ||
        sfr_addr_in == core_sfr_pkg::POINTER_LOW_ADDR ||
        sfr_addr_in == core_sfr_pkg::POINTER_HIGH_ADDR ||
        sfr_addr_in == core_sfr_pkg::STATUS_WORD_ADDR ||
        sfr_addr_in == core_sfr_pkg::PRIMARY_ADDR ||
        sfr_addr_in == core_sfr_pkg::SECONDARY_ADDR;

    // ****************************************************
    // Arithmetic flag unit
    // ****************************************************
    logic [7:0] arith_res_a;
    logic [7:0] arith_res_b;
    logic arith_b_write;
    logic arith_carry;
    logic arith_half;
    logic arith_range;

    arith_flag_unit u_arith (
        .op_in(arith_op_in),
        .acc_in(primary_working_reg_r),
        .b_in(secondary_working_reg_r),
        .operand_in(arith_operand_in),
        .carry_in(program_status_word_r[core_sfr_pkg::CARRY_POS]),
        .res_a_out(arith_res_a),
        .res_b_out(arith_res_b),
        .b_write_out(arith_b_write),
        .carry_out(arith_carry),
        .half_out(arith_half),
        .range_out(arith_range)
    );

    wire logic arith_active = arith_op_in != core_sfr_pkg::ARITH_NONE;

    // ****************************************************
    // Next-state logic
    // ****************************************************
    // Register writes land after arithmetic results, so software wins a collision
    always_comb begin
        primary_working_reg_nxt = primary_working_reg_r;
        if (arith_active) begin
            primary_working_reg_nxt = arith_res_a;
        end
        if (wr_primary) begin
            primary_working_reg_nxt = wr_data;
        end
    end

    always_comb begin
        secondary_working_reg_nxt = secondary_working_reg_r;
        if (arith_active && arith_b_write) begin
            secondary_working_reg_nxt = arith_res_b;
        end
        if (wr_secondary) begin
            secondary_working_reg_nxt = wr_data;
        end
    end

    always_comb begin
        program_status_word_nxt = program_status_word_r;
        if (arith_active) begin
            program_status_word_nxt[core_sfr_pkg::CARRY_POS] = arith_carry;
            program_status_word_nxt[core_sfr_pkg::HALF_CARRY_POS] = arith_half;
            // Flag unit reports all overflow causes and clears otherwise
            program_status_word_nxt[core_sfr_pkg::RANGE_POS] = arith_range;
        end
        // User flags and bank select change only through register writes
        if (wr_status) begin
            program_status_word_nxt[7:1] = wr_data[7:1];
        end
        // Parity is rebuilt from the accumulator, so a written value never sticks
        program_status_word_nxt[core_sfr_pkg::PARITY_POS] = ^primary_working_reg_nxt;
    end

    always_comb begin
        stack_top_pointer_nxt = stack_top_pointer_r;
        if (push_in && !pop_in) begin
            stack_top_pointer_nxt = stack_top_pointer_r + 8'h01;
        end else if (pop_in && !push_in) begin
            stack_top_pointer_nxt = stack_top_pointer_r - 8'h01;
        end
        if (wr_stack) begin
            stack_top_pointer_nxt = wr_data;
        end
    end

    wire logic [15:0] pointer_plus_one = {indirect_pointer_high_r, indirect_pointer_low_r} + 16'h0001;

    always_comb begin
        indirect_pointer_low_nxt = indirect_pointer_low_r;
        indirect_pointer_high_nxt = indirect_pointer_high_r;
        if (pointer_inc_in) begin
            indirect_pointer_low_nxt = pointer_plus_one[7:0];
            indirect_pointer_high_nxt = pointer_plus_one[15:8];
        end
        if (wr_low) begin
            indirect_pointer_low_nxt = wr_data;
        end
        if (wr_high) begin
            indirect_pointer_high_nxt = wr_data;
        end
    end

    // ****************************************************
    // Registers
    // ****************************************************
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            stack_top_pointer_r <= core_sfr_pkg::STACK_TOP_RESET;
            indirect_pointer_low_r <= core_sfr_pkg::POINTER_LOW_RESET;
            indirect_pointer_high_r <= core_sfr_pkg::POINTER_HIGH_RESET;
            program_status_word_r <= core_sfr_pkg::STATUS_WORD_RESET;
            primary_working_reg_r <= core_sfr_pkg::PRIMARY_RESET;
            secondary_working_reg_r <= core_sfr_pkg::SECONDARY_RESET;
        end else begin
            stack_top_pointer_r <= stack_top_pointer_nxt;
            indirect_pointer_low_r <= indirect_pointer_low_nxt;
            indirect_pointer_high_r <= indirect_pointer_high_nxt;
            program_status_word_r <= program_status_word_nxt;
            primary_working_reg_r <= primary_working_reg_nxt;
            secondary_working_reg_r <= secondary_working_reg_nxt;
        end
    end

    // Read data shows the register contents before any write of the same cycle
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sfr_rdata_r <= 8'h00;
            bit_rdata_r <= 1'b0;
        end else begin
            if (sfr_rd_in) begin
                sfr_rdata_r <= read_sfr(sfr_addr_in, stack_top_pointer_r, indirect_pointer_low_r,
                    indirect_pointer_high_r, program_status_word_r, primary_working_reg_r,
                    secondary_working_reg_r);
            end
            if (bit_rd_in) begin
                bit_rdata_r <= bit_target_ok & bit_byte_val[bit_addr_in[2:0]];
            end
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    assign sfr_rdata_out = sfr_rdata_r;
    assign bit_rdata_out = bit_rdata_r;
    assign stack_top_out = stack_top_pointer_r;
    assign indirect_pointer_out = {indirect_pointer_high_r, indirect_pointer_low_r};
    assign primary_working_reg_out = primary_working_reg_r;
    assign secondary_working_reg_out = secondary_working_reg_r;
    assign program_status_word_out = program_status_word_r;
    // Bank number times eight plus the register number
    assign working_reg_addr_out = {3'b000, program_status_word_r[core_sfr_pkg::BANK_HI_POS],
        program_status_word_r[core_sfr_pkg::BANK_LO_POS], working_reg_sel_in};

endmodule

// [core_special_registers_sva.sv]
`timescale 1ns/1ns
module core_sfr_sva (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic sfr_hit_out,
    input wire logic bit_wr_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic [7:0] stack_top_out,
    input wire logic pointer_inc_in,
    input wire logic [15:0] indirect_pointer_out,
    input wire core_sfr_pkg::arith_op_type arith_op_in,
    input wire logic [7:0] arith_operand_in,
    input wire logic [7:0] primary_working_reg_out,
    input wire logic [7:0] secondary_working_reg_out,
    input wire logic [7:0] program_status_word_out,
    input wire logic [2:0] working_reg_sel_in,
    input wire logic [7:0] working_reg_addr_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    // ****************************************************
    // Reference arithmetic, built from the current operands
    // ****************************************************
    wire logic [8:0] sum_w = {1'b0, primary_working_reg_out} + {1'b0, arith_operand_in};
    wire logic [7:0] sum_lo_w = sum_w[7:0];
    wire logic [4:0] nib_w = {1'b0, primary_working_reg_out[3:0]} + {1'b0, arith_operand_in[3:0]};
    wire logic ovf_w = (primary_working_reg_out[7] == arith_operand_in[7]) && (sum_w[7] != primary_working_reg_out[7]);
    wire logic [15:0] prod_w = primary_working_reg_out * secondary_working_reg_out;
    wire logic [1:0] user_w = {program_status_word_out[5], program_status_word_out[1]};
    wire logic [7:0] add_psw_w = {sum_w[8], nib_w[4], program_status_word_out[5:3], ovf_w,
                                  program_status_word_out[1], ^sum_lo_w};
    wire logic [15:0] pair_w = {secondary_working_reg_out, primary_working_reg_out};

    // Software writes win over hardware updates, so they are kept out of the antecedents
    sequence quiet_s; !sfr_wr_in && !bit_wr_in; endsequence
    sequence add_go_s; arith_op_in == core_sfr_pkg::ARITH_ADD ##0 quiet_s; endsequence
    sequence mul_go_s; arith_op_in == core_sfr_pkg::ARITH_MUL ##0 quiet_s; endsequence
    sequence div_zero_s; arith_op_in == core_sfr_pkg::ARITH_DIV && secondary_working_reg_out == 8'h00 ##0 quiet_s;
    endsequence

    stack_reset_a: assert property ($fell(rst_in) |-> stack_top_out == 8'h07)
        else $error("stack pointer not at reset value");
    push_step_a: assert property (push_in && !pop_in ##0 quiet_s |=>
        stack_top_out == $past(stack_top_out) + 8'h01)
        else $error("push did not advance the stack pointer by one");
    pointer_high_a: assert property (sfr_wr_in && sfr_addr_in == 8'h83 && !pointer_inc_in |=>
        indirect_pointer_out[15:8] == $past(sfr_wdata_in))
        else $error("high pointer byte not in bits 15 to 8");
    parity_live_a: assert property (program_status_word_out[0] == ^primary_working_reg_out)
        else $error("parity bit does not follow accumulator");
    bank_map_a: assert property (working_reg_addr_out ==
        {3'h0, program_status_word_out[4:3], working_reg_sel_in})
        else $error("working register address wrong for bank");
    hit_map_a: assert property (sfr_hit_out ==
        (sfr_addr_in inside {8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0}))
        else $error("address decode mismatch");
    unmapped_zero_a: assert property (sfr_rd_in && !sfr_hit_out |=> sfr_rdata_out == 8'h00)
        else $error("unmapped read returned nonzero");
    status_read_a: assert property (sfr_rd_in && sfr_addr_in == 8'hd0 |=>
        sfr_rdata_out == $past(program_status_word_out))
        else $error("status word read mismatch");
    add_flags_a: assert property (add_go_s |=>
        program_status_word_out == $past(add_psw_w) && primary_working_reg_out == $past(sum_lo_w))
        else $error("add result or flags wrong");
    mul_range_a: assert property (mul_go_s |=>
        pair_w == $past(prod_w) && program_status_word_out[2] == ($past(prod_w) > 16'h00ff))
        else $error("multiply result or range flag wrong");
    div_zero_a: assert property (div_zero_s |=> program_status_word_out[2] && $stable(pair_w))
        else $error("zero divide handling wrong");
    user_keep_a: assert property (arith_op_in != core_sfr_pkg::ARITH_NONE ##0 quiet_s |=> $stable(user_w))
        else $error("user flags changed by arithmetic");
endmodule

bind core_special_registers core_sfr_sva chk (.core_clk_in, .rst_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in,
    .sfr_rd_in, .sfr_rdata_out, .sfr_hit_out, .bit_wr_in, .push_in, .pop_in, .stack_top_out, .pointer_inc_in,
    .indirect_pointer_out, .arith_op_in, .arith_operand_in, .primary_working_reg_out, .secondary_working_reg_out,
    .program_status_word_out, .working_reg_sel_in, .working_reg_addr_out);

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic sfr_wr_in = 1'b0, sfr_rd_in = 1'b0, bit_wr_in = 1'b0, bit_wdata_in = 1'b0, bit_rd_in = 1'b0;
    logic push_in = 1'b0, pop_in = 1'b0, pointer_inc_in = 1'b0, sfr_hit_out, bit_rdata_out;
    logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, bit_addr_in = 8'h00, arith_operand_in = 8'h00;
    logic [7:0] sfr_rdata_out, stack_top_out, primary_working_reg_out, secondary_working_reg_out;
    logic [7:0] program_status_word_out, working_reg_addr_out;
    logic [2:0] working_reg_sel_in = 3'h0;
    logic [15:0] indirect_pointer_out;
    core_sfr_pkg::arith_op_type arith_op_in = core_sfr_pkg::ARITH_NONE;
    int num_errors = 0;
    int comparisons = 0;

    always #5 core_clk_in = ~core_clk_in;

    core_special_registers dut (.core_clk_in, .rst_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in, .sfr_rd_in,
        .sfr_rdata_out, .sfr_hit_out, .bit_addr_in, .bit_wr_in, .bit_wdata_in, .bit_rd_in, .bit_rdata_out,
        .push_in, .pop_in, .stack_top_out, .pointer_inc_in, .indirect_pointer_out, .arith_op_in,
        .arith_operand_in, .primary_working_reg_out, .secondary_working_reg_out, .program_status_word_out,
        .working_reg_sel_in, .working_reg_addr_out);

    // ****************************************************
    // Shared drivers, all launched at the falling edge
    // ****************************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge core_clk_in);
        sfr_addr_in = addr;
        sfr_wdata_in = data;
        sfr_wr_in = 1'b1;
        @(negedge core_clk_in);
        sfr_wr_in = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge core_clk_in);
        sfr_addr_in = addr;
        sfr_rd_in = 1'b1;
        @(negedge core_clk_in);
        sfr_rd_in = 1'b0;
        check(sfr_rdata_out, exp);
    endtask

    task automatic op(input core_sfr_pkg::arith_op_type code, input logic [7:0] operand);
        @(negedge core_clk_in);
        arith_op_in = code;
        arith_operand_in = operand;
        @(negedge core_clk_in);
        arith_op_in = core_sfr_pkg::ARITH_NONE;
    endtask

    task automatic results();
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_reset();
        check(stack_top_out, 8'h07);
        check({secondary_working_reg_out, primary_working_reg_out}, 16'h0000);
        check(program_status_word_out, 8'h00);
        rd_chk(8'h81, 8'h07);
    endtask

    task automatic t_regs();
        wr(8'h82, 8'hff);
        wr(8'h83, 8'h12);
        check(indirect_pointer_out, 16'h12ff);
        @(negedge core_clk_in);
        pointer_inc_in = 1'b1;
        @(negedge core_clk_in);
        pointer_inc_in = 1'b0;
        check(indirect_pointer_out, 16'h1300);
        wr(8'he0, 8'h03);
        wr(8'hf0, 8'h5a);
        rd_chk(8'he0, 8'h03);
        rd_chk(8'hf0, 8'h5a);
        // Parity of 0x03 is even, so the written one in bit 0 must not stick
        wr(8'hd0, 8'hff);
        rd_chk(8'hd0, 8'hfe);
        wr(8'ha5, 8'h77);
        rd_chk(8'ha5, 8'h00);
        check(sfr_hit_out, 1'b0);
        for (int i = 0; i < 4; i++) begin
            wr(8'hd0, 8'(i << 3));
            working_reg_sel_in = 3'h5;
            #1;
            check(working_reg_addr_out, 16'(i * 8 + 5));
        end
        @(negedge core_clk_in);
        bit_addr_in = 8'hd1;
        bit_wdata_in = 1'b1;
        bit_wr_in = 1'b1;
        @(negedge core_clk_in);
        bit_wr_in = 1'b0;
        bit_rd_in = 1'b1;
        @(negedge core_clk_in);
        bit_rd_in = 1'b0;
        check(bit_rdata_out, 1'b1);
        check(program_status_word_out, 8'h1a);
        // Parity is read-only, so a one set through bit access must not stick
        bit_addr_in = 8'hd0;
        bit_wr_in = 1'b1;
        @(negedge core_clk_in);
        bit_wr_in = 1'b0;
        bit_addr_in = 8'he2;
        bit_rd_in = 1'b1;
        @(negedge core_clk_in);
        bit_rd_in = 1'b0;
        check(program_status_word_out, 8'h1a);
        check(bit_rdata_out, 1'b0);
    endtask

    task automatic t_stack();
        @(negedge core_clk_in);
        push_in = 1'b1;
        repeat (2) @(negedge core_clk_in);
        push_in = 1'b0;
        check(stack_top_out, 8'h09);
        @(negedge core_clk_in);
        pop_in = 1'b1;
        @(negedge core_clk_in);
        pop_in = 1'b0;
        check(stack_top_out, 8'h08);
        @(negedge core_clk_in);
        push_in = 1'b1;
        pop_in = 1'b1;
        @(negedge core_clk_in);
        push_in = 1'b0;
        pop_in = 1'b0;
        check(stack_top_out, 8'h08);
    endtask

    task automatic t_arith();
        wr(8'he0, 8'h7f);
        wr(8'hd0, 8'h22);
        check(program_status_word_out, 8'h23);
        op(core_sfr_pkg::ARITH_ADD, 8'h01);
        check({primary_working_reg_out, program_status_word_out}, 16'h8067);
        op(core_sfr_pkg::ARITH_ADDC, 8'h80);
        check({primary_working_reg_out, program_status_word_out}, 16'h00a6);
        op(core_sfr_pkg::ARITH_SUBB, 8'h00);
        check({primary_working_reg_out, program_status_word_out}, 16'hffe2);
        wr(8'he0, 8'h20);
        wr(8'hf0, 8'h10);
        op(core_sfr_pkg::ARITH_MUL, 8'h00);
        check({secondary_working_reg_out, primary_working_reg_out}, 16'h0200);
        check(program_status_word_out, 8'h26);
        wr(8'he0, 8'h11);
        wr(8'hf0, 8'h05);
        op(core_sfr_pkg::ARITH_DIV, 8'h00);
        check({secondary_working_reg_out, primary_working_reg_out}, 16'h0203);
        check(program_status_word_out, 8'h22);
        wr(8'hf0, 8'h00);
        op(core_sfr_pkg::ARITH_DIV, 8'h00);
        check({secondary_working_reg_out, primary_working_reg_out}, 16'h0003);
        check(program_status_word_out, 8'h26);
        op(core_sfr_pkg::ARITH_MUL, 8'h00);
        check(program_status_word_out, 8'h22);
    endtask

    initial begin
        #100000;
        num_errors++;
        results();
    end

    initial begin
        repeat (8) @(negedge core_clk_in);
        rst_in = 1'b0;
        t_reset();
        t_regs();
        t_stack();
        t_arith();
        results();
    end
endmodule
